// ===== core_alu_pkg.sv
// shared types and constants for the core alu instruction block
package core_alu_pkg;

   localparam int          DATA_W      = 8;          // data path width
   localparam int          PC_W        = 11;         // program counter width
   localparam int          STACK_DEPTH = 8;          // hardware stack levels
   localparam int          SP_W        = 3;          // stack pointer width
   localparam int          MEM_DEPTH   = 256;        // data memory registers
   localparam logic [7:0]  ACC_RST     = 8'h00;      // accumulator after reset
   localparam logic [10:0] PC_RST      = 11'h000;    // program counter after reset
   localparam logic [2:0]  SP_RST      = 3'h0;       // stack pointer after reset
   localparam logic [7:0]  ALL_ONES    = 8'hFF;      // set-register value
   localparam logic [7:0]  BIT_ONE     = 8'h01;      // single bit mask seed
   localparam logic [7:0]  ZERO_BYTE   = 8'h00;      // zero compare value
   localparam int          CYC_ONE     = 1;          // single cycle instruction
   localparam int          CYC_TWO     = 2;          // two cycle instruction

   // instruction operation codes
   typedef enum logic [5:0] {
      no_operation, rev_sub_to_reg, rev_sub_carry_to_acc, rev_sub_carry_to_reg,
      increment_to_acc, increment_to_reg, jump_uncond, move_to_acc, move_to_reg,
      load_immediate, or_immediate, or_reg_to_acc, or_reg_to_reg,
      return_sub, return_value, return_interrupt,
      rot_left_carry_acc, rot_left_carry_reg, rot_left_acc, rot_left_reg,
      rot_right_carry_acc, rot_right_carry_reg, rot_right_acc, rot_right_reg,
      set_all_reg, set_one_bit, sleep_enter, sub_immediate,
      fwd_sub_to_acc, fwd_sub_to_reg, fwd_sub_carry_acc, fwd_sub_carry_reg,
      nibble_swap_acc, nibble_swap_reg
   } op_e;

   // one issued instruction
   typedef struct packed {
      op_e         op;       // operation
      logic [7:0]  addr;     // data memory register address
      logic [2:0]  bitsel;   // bit number for set_one_bit
      logic [7:0]  imm;      // immediate operand
      logic [10:0] target;   // jump target
   } instr_s;

   // status flags
   typedef struct packed {
      logic carry_flag;
      logic digit_carry_flag;
      logic zero_flag;
      logic overflow_flag;
      logic timeout_flag;
      logic powerdown_flag;
   } flags_s;

   // register write-back report
   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
      logic [7:0] data;
   } wb_s;

   // subtract result
   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       dc;
      logic       ov;
   } arith_s;

   localparam flags_s FLAGS_RST = '{default: 1'b0, timeout_flag: 1'b1,
                                    powerdown_flag: 1'b1};

endpackage

// ===== core_alu.sv
// core alu executing subtract, increment, move, or, rotate, set, return, sleep and swap
//
// Overview of operation
// RULE_01: reverse subtract with carry: acc-reg-c to reg or acc
// RULE_02: increment register, to reg or acc, z only
// RULE_03: jump loads target, two cycles, flags kept
// RULE_04: move register to acc, updates zero flag
// RULE_05: move acc to register, no flags
// RULE_06: load immediate into acc, no flags
// RULE_07: or with reg or immediate, z only
// RULE_08: return pops stack, two cycles, no flags
// RULE_09: return also loads immediate into acc
// RULE_10: rotate left through carry, carry only
// RULE_11: rotate left without carry, no flags
// RULE_12: rotate right through carry, carry only
// RULE_13: rotate right without carry, no flags
// RULE_14: set register to all ones, no flags
// RULE_15: set one selected bit, no flags
// RULE_16: sleep sets timeout, clears powerdown, halts core
// RULE_17: forward subtract reg-acc, arithmetic flags
// RULE_18: forward subtract with carry reg-acc-c
// RULE_19: swap nibbles to reg or acc, no flags
// RULE_20: interrupt return pops stack, two cycles
// RULE_21: immediate minus acc into acc, arithmetic flags
`timescale 1ns/10ps
`default_nettype none

module core_alu (
   // clock and reset
   input  wire logic                  I_CLK,
   input  wire logic                  I_RST,
   // instruction issue
   input  wire logic                  I_VALID,
   input  wire core_alu_pkg::instr_s  I_INSTR,
   // stack push from the call sequencer
   input  wire logic                  I_PUSH,
   input  wire logic [10:0]           I_PUSH_ADDR,
   // wake request pin
   input  wire logic                  I_WAKE,
   // core state
   output logic [7:0]                 O_ACC,
   output core_alu_pkg::flags_s       O_FLAGS,
   output logic [10:0]                O_PC,
   output logic                       O_BUSY,
   output logic                       O_SLEEP,
   output core_alu_pkg::wb_s          O_WB
);
   import core_alu_pkg::*;

   logic [7:0]  mem [MEM_DEPTH];      // data memory registers
   logic [10:0] stack [STACK_DEPTH];  // return address stack
   logic [2:0]  sp;                   // next free stack slot
   logic        wake_s1;              // wake synchroniser stages
   logic        wake_s2;
   logic        wake_s3;
   logic        take;                 // instruction accepted this cycle
   logic [7:0]  rd;                   // addressed register value
   logic [7:0]  next_res;             // result byte
   logic        wr_acc;               // result goes to accumulator
   logic        wr_reg;               // result goes to register
   logic        upd_z;                // zero flag follows result
   logic        upd_arith;            // c, dc, ov follow subtract
   logic        upd_c;                // carry follows rotate
   logic        next_c;               // rotate carry out
   logic        two_cyc;              // instruction needs a second cycle
   logic        do_jump;              // load pc from target
   logic        do_pop;               // load pc from stack
   logic        do_sleep;             // enter sleep
   arith_s      ar;                   // subtract flags

   // subtract a-b-borrow with no-borrow carry semantics
   function automatic arith_s sub_op(input logic [7:0] a, input logic [7:0] b,
                                     input logic bin);
      arith_s     r;
      logic [8:0] d;
      logic [4:0] h;
      d     = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      h     = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      r.res = d[7:0];
      r.c   = ~d[8];
      r.dc  = ~h[4];
      r.ov  = (a[7] ^ b[7]) & (a[7] ^ d[7]);
      return r;
   endfunction

   // requests are refused while busy or asleep
   assign take = I_VALID & ~O_BUSY & ~O_SLEEP;
   assign rd   = mem[I_INSTR.addr];

   // instruction decode and result computation
   always_comb begin
      next_res  = ZERO_BYTE;
      wr_acc    = 1'b0;
      wr_reg    = 1'b0;
      upd_z     = 1'b0;
      upd_arith = 1'b0;
      upd_c     = 1'b0;
      next_c    = O_FLAGS.carry_flag;
      two_cyc   = 1'b0;
      do_jump   = 1'b0;
      do_pop    = 1'b0;
      do_sleep  = 1'b0;
      ar        = '0;
      case (I_INSTR.op)
         rev_sub_to_reg, rev_sub_carry_to_acc, rev_sub_carry_to_reg: begin
            // acc minus reg, borrow only on the carry forms
            ar        = sub_op(O_ACC, rd, (I_INSTR.op != rev_sub_to_reg) &
                               O_FLAGS.carry_flag);                      // [RULE_01]
            next_res  = ar.res;
            upd_arith = 1'b1;
            upd_z     = 1'b1;
            wr_acc    = (I_INSTR.op == rev_sub_carry_to_acc);
            wr_reg    = ~wr_acc;
         end
         fwd_sub_to_acc, fwd_sub_to_reg: begin
            ar        = sub_op(rd, O_ACC, 1'b0);                          // [RULE_17]
            next_res  = ar.res;
            upd_arith = 1'b1;
            upd_z     = 1'b1;
            wr_acc    = (I_INSTR.op == fwd_sub_to_acc);
            wr_reg    = ~wr_acc;
         end
         fwd_sub_carry_acc, fwd_sub_carry_reg: begin
            ar        = sub_op(rd, O_ACC, O_FLAGS.carry_flag);            // [RULE_18]
            next_res  = ar.res;
            upd_arith = 1'b1;
            upd_z     = 1'b1;
            wr_acc    = (I_INSTR.op == fwd_sub_carry_acc);
            wr_reg    = ~wr_acc;
         end
         sub_immediate: begin
            ar        = sub_op(I_INSTR.imm, O_ACC, 1'b0);                 // [RULE_21]
            next_res  = ar.res;
            upd_arith = 1'b1;
            upd_z     = 1'b1;
            wr_acc    = 1'b1;
         end
         increment_to_acc, increment_to_reg: begin
            next_res = rd + BIT_ONE;                                      // [RULE_02]
            upd_z    = 1'b1;
            wr_acc   = (I_INSTR.op == increment_to_acc);
            wr_reg   = ~wr_acc;
         end
         jump_uncond: begin
            do_jump = 1'b1;                                               // [RULE_03]
            two_cyc = 1'b1;
         end
         move_to_acc: begin
            next_res = rd;                                                // [RULE_04]
            upd_z    = 1'b1;
            wr_acc   = 1'b1;
         end
         move_to_reg: begin
            next_res = O_ACC;                                             // [RULE_05]
            wr_reg   = 1'b1;
         end
         load_immediate: begin
            next_res = I_INSTR.imm;                                       // [RULE_06]
            wr_acc   = 1'b1;
         end
         or_immediate: begin
            next_res = O_ACC | I_INSTR.imm;                               // [RULE_07]
            upd_z    = 1'b1;
            wr_acc   = 1'b1;
         end
         or_reg_to_acc, or_reg_to_reg: begin
            next_res = O_ACC | rd;                                        // [RULE_07]
            upd_z    = 1'b1;
            wr_acc   = (I_INSTR.op == or_reg_to_acc);
            wr_reg   = ~wr_acc;
         end
         return_sub, return_interrupt: begin
            do_pop  = 1'b1;                                               // [RULE_08] [RULE_20]
            two_cyc = 1'b1;
         end
         return_value: begin
            do_pop   = 1'b1;                                              // [RULE_09]
            two_cyc  = 1'b1;
            next_res = I_INSTR.imm;
            wr_acc   = 1'b1;
         end
         rot_left_carry_acc, rot_left_carry_reg: begin
            next_res = {rd[6:0], O_FLAGS.carry_flag};                     // [RULE_10]
            next_c   = rd[7];
            upd_c    = 1'b1;
            wr_acc   = (I_INSTR.op == rot_left_carry_acc);
            wr_reg   = ~wr_acc;
         end
         rot_left_acc, rot_left_reg: begin
            next_res = {rd[6:0], rd[7]};                                  // [RULE_11]
            wr_acc   = (I_INSTR.op == rot_left_acc);
            wr_reg   = ~wr_acc;
         end
         rot_right_carry_acc, rot_right_carry_reg: begin
            next_res = {O_FLAGS.carry_flag, rd[7:1]};                     // [RULE_12]
            next_c   = rd[0];
            upd_c    = 1'b1;
            wr_acc   = (I_INSTR.op == rot_right_carry_acc);
            wr_reg   = ~wr_acc;
         end
         rot_right_acc, rot_right_reg: begin
            next_res = {rd[0], rd[7:1]};                                  // [RULE_13]
            wr_acc   = (I_INSTR.op == rot_right_acc);
            wr_reg   = ~wr_acc;
         end
         set_all_reg: begin
            next_res = ALL_ONES;                                          // [RULE_14]
            wr_reg   = 1'b1;
         end
         set_one_bit: begin
            next_res = rd | (BIT_ONE << I_INSTR.bitsel);                  // [RULE_15]
            wr_reg   = 1'b1;
         end
         sleep_enter: begin
            do_sleep = 1'b1;                                              // [RULE_16]
         end
         nibble_swap_acc, nibble_swap_reg: begin
            next_res = {rd[3:0], rd[7:4]};                                // [RULE_19]
            wr_acc   = (I_INSTR.op == nibble_swap_acc);
            wr_reg   = ~wr_acc;
         end
         default: begin
            // no_operation: only the pc advances
         end
      endcase
   end

   // wake pin synchroniser, three stages
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         wake_s1 <= 1'b0;
         wake_s2 <= 1'b0;
         wake_s3 <= 1'b0;
      end else begin
         wake_s1 <= I_WAKE;
         wake_s2 <= wake_s1;
         wake_s3 <= wake_s2;
      end
   end

   // sleep state: entered by instruction, left on an agreed wake level
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_SLEEP <= 1'b0;
      end else if (take & do_sleep) begin
         O_SLEEP <= 1'b1;                                                 // [RULE_16]
      end else if (wake_s2 & wake_s3) begin
         O_SLEEP <= 1'b0;
      end
   end

   // second cycle of two cycle instructions
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_BUSY <= 1'b0;
      end else begin
         O_BUSY <= take & two_cyc;                                        // [RULE_03] [RULE_08]
      end
   end

   // program counter
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_PC <= PC_RST;
      end else if (take) begin
         if (do_jump) begin
            O_PC <= I_INSTR.target;                                       // [RULE_03]
         end else if (do_pop) begin
            O_PC <= stack[sp - 3'h1];                                     // [RULE_08] [RULE_20]
         end else begin
            O_PC <= O_PC + 11'h001;
         end
      end
   end

   // return stack, circular over its eight levels
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sp <= SP_RST;
      end else if (take & do_pop) begin
         sp <= sp - 3'h1;
      end else if (I_PUSH) begin
         stack[sp] <= I_PUSH_ADDR;
         sp        <= sp + 3'h1;
      end
   end

   // accumulator
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_ACC <= ACC_RST;
      end else if (take & wr_acc) begin
         O_ACC <= next_res;
      end
   end

   // data memory write and its report
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_WB <= '0;
      end else begin
         O_WB.valid <= take & wr_reg;
         O_WB.addr  <= I_INSTR.addr;
         O_WB.data  <= next_res;
         if (take & wr_reg) begin
            mem[I_INSTR.addr] <= next_res;
         end
      end
   end

   // status flags, each only when its instruction affects it
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_FLAGS <= FLAGS_RST;
      end else if (take) begin
         if (upd_z) begin
            O_FLAGS.zero_flag <= (next_res == ZERO_BYTE);
         end
         if (upd_arith) begin
            O_FLAGS.carry_flag       <= ar.c;
            O_FLAGS.digit_carry_flag <= ar.dc;
            O_FLAGS.overflow_flag    <= ar.ov;
         end
         if (upd_c) begin
            O_FLAGS.carry_flag <= next_c;
         end
         if (do_sleep) begin
            O_FLAGS.timeout_flag   <= 1'b1;
            O_FLAGS.powerdown_flag <= 1'b0;
         end
      end
   end

   property p_rev_sub;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == rev_sub_carry_to_reg |=>
         O_WB.valid && O_WB.data == $past(O_ACC - rd - {7'h0, O_FLAGS.carry_flag});
   endproperty
   a_rev_sub: assert property (p_rev_sub) else $error("reverse subtract wrong"); // [RULE_01]

   property p_inc;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == increment_to_acc |=>
         O_ACC == $past(rd + 8'h01) && O_FLAGS.carry_flag == $past(O_FLAGS.carry_flag);
   endproperty
   a_inc: assert property (p_inc) else $error("increment wrong"); // [RULE_02]

   property p_jump;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == jump_uncond |=>
         O_PC == $past(I_INSTR.target) && O_BUSY && O_FLAGS == $past(O_FLAGS) ##1 !O_BUSY;
   endproperty
   a_jump: assert property (p_jump) else $error("jump wrong"); // [RULE_03]

   property p_move_acc;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == move_to_acc |=>
         O_ACC == $past(rd) && O_FLAGS.zero_flag == (O_ACC == 8'h00);
   endproperty
   a_move_acc: assert property (p_move_acc) else $error("move to acc wrong"); // [RULE_04]

   property p_move_reg;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == move_to_reg |=>
         O_WB.valid && O_WB.data == $past(O_ACC) && $stable(O_FLAGS);
   endproperty
   a_move_reg: assert property (p_move_reg) else $error("move to reg wrong"); // [RULE_05]

   property p_load_imm;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == load_immediate |=> O_ACC == $past(I_INSTR.imm) && $stable(O_FLAGS);
   endproperty
   a_load_imm: assert property (p_load_imm) else $error("load immediate wrong"); // [RULE_06]

   property p_or_imm;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == or_immediate |=> O_ACC == $past(O_ACC | I_INSTR.imm);
   endproperty
   a_or_imm: assert property (p_or_imm) else $error("or immediate wrong"); // [RULE_07]

   property p_rot_lc;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == rot_left_carry_acc |=>
         O_ACC == $past({rd[6:0], O_FLAGS.carry_flag}) && O_FLAGS.carry_flag == $past(rd[7]);
   endproperty
   a_rot_lc: assert property (p_rot_lc) else $error("rotate left carry wrong"); // [RULE_10]

   property p_sleep;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == sleep_enter |=>
         O_SLEEP && O_FLAGS.timeout_flag && !O_FLAGS.powerdown_flag;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong"); // [RULE_16]

   property p_swap;
      @(posedge I_CLK) disable iff (I_RST)
      take && I_INSTR.op == nibble_swap_reg |=>
         O_WB.valid && O_WB.data == $past({rd[3:0], rd[7:4]}) && $stable(O_FLAGS);
   endproperty
   a_swap: assert property (p_swap) else $error("nibble swap wrong"); // [RULE_19]

endmodule

`default_nettype wire

// ===== tb_top.sv
// self-checking testbench for the core alu instruction block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import core_alu_pkg::*;
   logic        clk;              // core clock
   logic        rst;              // synchronous reset
   logic        valid;            // instruction offered
   instr_s      instr;            // offered instruction
   logic        push;             // return stack push
   logic [10:0] push_addr;        // pushed return address
   logic        wake;             // wake pin
   logic [7:0]  acc;              // accumulator view
   flags_s      flags;            // status flags view
   logic [10:0] pc;               // program counter view
   logic        busy;             // second cycle of a long op
   logic        sleeping;         // core halted
   wb_s         wb;               // register write report
   int          n_errors = 0;     // mismatches seen
   int          comparisons = 0;  // compares made

   core_alu uut (.I_CLK(clk), .I_RST(rst), .I_VALID(valid), .I_INSTR(instr), .I_PUSH(push),
                 .I_PUSH_ADDR(push_addr), .I_WAKE(wake), .O_ACC(acc), .O_FLAGS(flags),
                 .O_PC(pc), .O_BUSY(busy), .O_SLEEP(sleeping), .O_WB(wb));

   // free running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
      end
   endtask

   // offer one instruction once the core is free, release after the taking edge
   task automatic exec(input op_e op, input logic [7:0] ad, input logic [7:0] im);
      while (busy) @(posedge clk) #1;
      instr = '{op: op, addr: ad, bitsel: 3'd3, imm: im, target: 11'h2A5};
      valid = 1'b1;
      @(posedge clk) #1;
      valid = 1'b0;
   endtask

   // write a data memory register through the accumulator, flags untouched
   task automatic poke(input logic [7:0] ad, input logic [7:0] v);
      exec(load_immediate, 8'h00, v);
      exec(move_to_reg, ad, 8'h00);
   endtask

   // set carry to c by rotating a known byte through it
   task automatic setc(input logic c);
      poke(8'h06, {c, 7'h00});
      exec(rot_left_carry_acc, 8'h06, 8'h00);
   endtask

   // reference subtract: x - y - b, carry and digit carry mean no borrow
   function automatic arith_s sub_ref(input logic [7:0] x, input logic [7:0] y, input logic b);
      logic [8:0] d;
      logic [4:0] n;
      d = {1'b0, x} - {1'b0, y} - {8'h00, b};
      n = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, b};
      sub_ref = '{res: d[7:0], c: ~d[8], dc: ~n[4], ov: (x[7] ^ y[7]) & (x[7] ^ d[7])};
   endfunction

   // reference for one-operand ops: {new carry, result}
   function automatic logic [8:0] un_ref(input op_e op, input logic [7:0] v,
                                         input logic [7:0] a, input logic c);
      case (op)
         increment_to_acc, increment_to_reg: un_ref = {c, v + 8'h01};
         or_reg_to_acc, or_reg_to_reg, or_immediate: un_ref = {c, v | a};
         rot_left_carry_acc, rot_left_carry_reg: un_ref = {v, c};
         rot_left_acc, rot_left_reg: un_ref = {c, v[6:0], v[7]};
         rot_right_carry_acc, rot_right_carry_reg: un_ref = {v[0], c, v[7:1]};
         rot_right_acc, rot_right_reg: un_ref = {c, v[0], v[7:1]};
         set_all_reg: un_ref = {c, 8'hFF};
         set_one_bit: un_ref = {c, v | 8'h08};
         default: un_ref = {c, v[3:0], v[7:4]};
      endcase
   endfunction

   // moves and immediate load
   task automatic t_move();
      flags_s f;
      f = flags;
      exec(load_immediate, 8'h00, 8'h35);
      chk(acc, 8'h35, "load imm");
      exec(move_to_reg, 8'h01, 8'h00);
      chk(wb, {1'b1, 8'h01, 8'h35}, "move to reg");
      chk(flags, f, "move flags");
      exec(load_immediate, 8'h00, 8'h00);
      chk(wb.valid, 1'b0, "write pulse length");
      exec(move_to_acc, 8'h01, 8'h00);
      chk({acc, flags.zero_flag}, {8'h35, 1'b0}, "move to acc");
      poke(8'h07, 8'h00);
      exec(load_immediate, 8'h00, 8'h5A);
      exec(move_to_acc, 8'h07, 8'h00);
      chk({acc, flags.zero_flag}, {8'h00, 1'b1}, "move zero");
   endtask

   // every subtract form, both carries, a borrowing and a zero case
   task automatic t_sub();
      op_e        ops[8] = '{rev_sub_to_reg, rev_sub_carry_to_acc, rev_sub_carry_to_reg,
                             fwd_sub_to_acc, fwd_sub_to_reg, fwd_sub_carry_acc,
                             fwd_sub_carry_reg, sub_immediate};
      logic [7:0] av[2] = '{8'h80, 8'h45};
      logic [7:0] rv[2] = '{8'h77, 8'h45};
      arith_s     e;
      logic       cu;
      logic       rg;
      for (int i = 0; i < 8; i++) begin
         for (int k = 0; k < 4; k++) begin
            setc(k[0]);
            poke(8'h02, rv[k[1]]);
            exec(load_immediate, 8'h00, av[k[1]]);
            cu = k[0] & (ops[i] inside {rev_sub_carry_to_acc, rev_sub_carry_to_reg,
                                        fwd_sub_carry_acc, fwd_sub_carry_reg});
            rg = ops[i] inside {rev_sub_to_reg, rev_sub_carry_to_reg, fwd_sub_to_reg,
                                fwd_sub_carry_reg};
            if (i < 3) e = sub_ref(av[k[1]], rv[k[1]], cu);
            else e = sub_ref(rv[k[1]], av[k[1]], cu);
            exec(ops[i], 8'h02, rv[k[1]]);
            if (rg) chk(wb, {1'b1, 8'h02, e.res}, "sub reg");
            else chk(acc, e.res, "sub acc");
            chk(flags, {e.c, e.dc, e.res == 8'h00, e.ov, 2'b11}, "sub flags");
         end
      end
   endtask

   // increment, or, rotates, set and swap over edge values and both carries
   task automatic t_unary();
      op_e        ops[17] = '{increment_to_acc, increment_to_reg, or_reg_to_acc, or_reg_to_reg,
                              or_immediate, rot_left_carry_acc, rot_left_carry_reg,
                              rot_left_acc, rot_left_reg, rot_right_carry_acc,
                              rot_right_carry_reg, rot_right_acc, rot_right_reg, set_all_reg,
                              set_one_bit, nibble_swap_acc, nibble_swap_reg};
      logic [7:0] vals[4] = '{8'h0A, 8'hFF, 8'h00, 8'h81};
      logic [8:0] e;
      logic [7:0] a;
      flags_s     f;
      logic       rg;
      for (int i = 0; i < 17; i++) begin
         for (int k = 0; k < 8; k++) begin
            a = (vals[k[2:1]] == 8'h00) ? 8'h00 : 8'h30;
            setc(k[0]);
            poke(8'h05, vals[k[2:1]]);
            exec(load_immediate, 8'h00, a);
            f = flags;
            e = un_ref(ops[i], vals[k[2:1]], a, k[0]);
            if (i < 5) f.zero_flag = (e[7:0] == 8'h00);
            f.carry_flag = e[8];
            rg = ops[i] inside {increment_to_reg, or_reg_to_reg, rot_left_carry_reg,
                                rot_left_reg, rot_right_carry_reg, rot_right_reg,
                                set_all_reg, set_one_bit, nibble_swap_reg};
            exec(ops[i], 8'h05, vals[k[2:1]]);
            if (rg) chk({wb, acc}, {1'b1, 8'h05, e[7:0], a}, "unary reg");
            else chk(acc, e[7:0], "unary acc");
            chk(flags, f, "unary flags");
         end
      end
   endtask

   // jump, refused offer while busy, stacked returns
   task automatic t_flow();
      flags_s      f;
      logic [10:0] p;
      exec(load_immediate, 8'h00, 8'h00);
      f = flags;
      p = pc;
      exec(no_operation, 8'h00, 8'h00);
      chk(pc, p + 11'h001, "nop advance");
      exec(jump_uncond, 8'h00, 8'h00);
      chk({pc, busy}, {11'h2A5, 1'b1}, "jump");
      instr.op = load_immediate;
      instr.imm = 8'h11;
      valid = 1'b1;
      @(posedge clk) #1;
      chk({acc, busy}, {8'h00, 1'b0}, "offer while busy");
      @(posedge clk) #1;
      valid = 1'b0;
      chk(acc, 8'h11, "offer after busy");
      push_addr = 11'h123;
      push = 1'b1;
      @(posedge clk) #1;
      push_addr = 11'h456;
      @(posedge clk) #1;
      push = 1'b0;
      exec(return_sub, 8'h00, 8'h00);
      chk({pc, busy}, {11'h456, 1'b1}, "return");
      exec(return_value, 8'h00, 8'h35);
      chk({pc, acc}, {11'h123, 8'h35}, "return value");
      push_addr = 11'h321;
      push = 1'b1;
      @(posedge clk) #1;
      push = 1'b0;
      exec(return_interrupt, 8'h00, 8'h00);
      chk({pc, busy}, {11'h321, 1'b1}, "interrupt return");
      chk(flags, f, "flow flags");
   endtask

   // sleep entry, refused offer, wake through the pin
   task automatic t_sleep();
      exec(sleep_enter, 8'h00, 8'h00);
      chk({sleeping, flags.timeout_flag, flags.powerdown_flag}, 3'b110, "sleep");
      exec(load_immediate, 8'h00, 8'hC3);
      repeat (3) @(posedge clk) #1;
      chk({sleeping, acc}, {1'b1, 8'h35}, "halted");
      wake = 1'b1;
      for (int n = 0; n < 10 && sleeping; n++) @(posedge clk) #1;
      wake = 1'b0;
      chk(sleeping, 1'b0, "wake");
      exec(load_immediate, 8'h00, 8'hC3);
      chk(acc, 8'hC3, "run after wake");
   endtask

   // report counts and verdict, end the run
   task automatic conclude();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      valid = 1'b0;
      instr = '0;
      push = 1'b0;
      push_addr = 11'h000;
      wake = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      chk({acc, pc, flags, busy, sleeping, wb}, {8'h00, 11'h000, 6'b000011, 2'b00, 17'h0_0000},
          "reset values");
      t_move();
      t_sub();
      t_unary();
      t_flow();
      t_sleep();
      conclude();
   end

   // watchdog, well beyond the expected run length
   initial begin
      #200000;
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire
